// ===== design/sysrcc_top.v
// Reset sequencing, clock gating and status registers of the system block
//
// What this block does
// - Bus runs at a quarter of the chosen oscillator or PLL source
// - Bus clock is the clock generator output divided by two
// - After power-on, clocks stay off for 4096 reference cycles, then start
// - Reset pin is driven low for the whole power-on timeout
// - Stop exit counts 4096 or 32 reference cycles before clocks resume
// - Wait mode stops CPU clocks; two peripheral clock sets keep running
// - Every reset asserts internal reset and selects user or monitor vector
// - Internal reset returns registers and modules to their defaults
// - Internal resets clear the counter; pin resets leave it alone
// - Each reset sets the matching reset-cause flag
// - Reset pin is asynchronous; pulling it low halts processing
// - Pin flag needs 67 low reference cycles, not for power-on resets
// - After power-on or low voltage the pin flag needs 4163 cycles
// - Reset-cause register layout; only the power-on flag resets to one
// - Break-in-stop-or-wait flag resets to zero, cleared by writing zero
// - Break control holds a read/write clear enable in bit 7
// - Internal resets drive the pin 32 cycles, then hold reset 32 more
// - Counter is 13 bits and advances on reference clock falling edges
// - After the 4096 count, wait 64 more cycles before releasing the CPU
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "sysrcc_regs.vh"
module sysrcc_top #(
	parameter ADDR_W = 18,
	parameter CNT_W  = 13
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [17:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata_q,
	output reg         pready_q,
	output reg         pslverr_q,
	input  wire        osc_ref_clock,
	input  wire        clock_gen_output,
	input  wire        rst_pin_in,
	output reg         rst_pin_out_q,
	output reg         rst_pin_oe_q,
	input  wire        low_voltage_req,
	input  wire        watchdog_req,
	input  wire        bad_opcode_req,
	input  wire        bad_address_req,
	input  wire        monitor_mode,
	input  wire        wait_mode,
	input  wire        stop_mode,
	input  wire        short_stop_recovery,
	input  wire        break_req,
	input  wire        break_active,
	output reg         pll_select_q,
	output reg         internal_reset_q,
	output reg  [15:0] reset_vector_q,
	output reg         cpu_clk_q,
	output reg         periph_clk_a_q,
	output reg         periph_clk_b_q
);
	localparam [2:0] S_RUN      = 3'd0;
	localparam [2:0] S_POR      = 3'd1;
	localparam [2:0] S_POR_TAIL = 3'd2;
	localparam [2:0] S_INT_PIN  = 3'd3;
	localparam [2:0] S_INT_HOLD = 3'd4;
	localparam [2:0] S_EXT      = 3'd5;
	localparam [2:0] S_STOP     = 3'd6;
	localparam [2:0] S_STOP_REC = 3'd7;

	localparam [CNT_W-1:0] POR_LAST  = `SYSRCC_POR_CYCLES - 13'd1;
	localparam [CNT_W-1:0] STOP_LONG = `SYSRCC_STOP_LONG_CYCLES - 13'd1;
	localparam [CNT_W-1:0] STOP_SHRT = `SYSRCC_STOP_SHORT_CYCLES - 13'd1;
	localparam [CNT_W-1:0] PIN_MIN   = `SYSRCC_PIN_MIN_CYCLES - 13'd1;
	localparam [CNT_W-1:0] PIN_POR   = `SYSRCC_PIN_POR_CYCLES - 13'd1;
	localparam [6:0]       TAIL_FULL = `SYSRCC_POR_TAIL_CYCLES - 7'd1;
	localparam [5:0]       TAIL_LAST = TAIL_FULL[5:0];
	localparam [5:0]       DRV_LAST  = `SYSRCC_INT_PIN_CYCLES - 6'd1;
	localparam [5:0]       HOLD_LAST = `SYSRCC_INT_HOLD_CYCLES - 6'd1;

	wire [3:0] sync_level;
	wire [3:0] sync_rise;
	wire [3:0] sync_fall;
	wire       ref_fall;
	wire       cgo_rise;
	wire       pin_high;
	wire       lvi_rise;
	wire       bus_clk;

	reg [2:0]       state_q;
	reg [CNT_W-1:0] sim_cnt_q;
	reg [5:0]       ph_cnt_q;
	reg [CNT_W-1:0] pin_cnt_q;
	reg             por_type_q;
	reg [7:0]       cause_q;
	reg             brk_sw_q;
	reg             break_flag_clear_enable_q;

	// Pins: reference clock, clock generator output, reset pin, low voltage
	sysrcc_sync #(
		.W    (4),
		.INIT (4'b0100)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({low_voltage_req, rst_pin_in, clock_gen_output,
		           osc_ref_clock}),
		.level   (sync_level),
		.rise    (sync_rise),
		.fall    (sync_fall)
	);

	assign ref_fall = sync_fall[0];
	assign cgo_rise = sync_rise[1];
	assign pin_high = sync_level[2];
	assign lvi_rise = sync_rise[3];

	// Clock generator output is the selected source halved
	sysrcc_clkdiv #(
		.DIV (`SYSRCC_BUS_DIV),
		.CW  (4)
	) u_div (
		.pclk      (pclk),
		.presetn   (presetn),
		.tick      (cgo_rise),
		.div_clk_q (bus_clk)
	);

	wire int_req = watchdog_req | bad_opcode_req | bad_address_req;
	wire int_ok  = (state_q == S_RUN) | (state_q == S_EXT) |
	               (state_q == S_STOP) | (state_q == S_STOP_REC);
	wire pin_watch = (state_q == S_RUN) | (state_q == S_STOP) |
	                 (state_q == S_STOP_REC);
	wire [CNT_W-1:0] pin_thr  = por_type_q ? PIN_POR : PIN_MIN;
	wire [CNT_W-1:0] stop_thr = short_stop_recovery ? STOP_SHRT : STOP_LONG;
	wire [7:0] int_cause = {2'b00, watchdog_req, bad_opcode_req,
	                        bad_address_req, 3'b000};

	// Reset sequencer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= S_POR;
			sim_cnt_q  <= {CNT_W{1'b0}};
			ph_cnt_q   <= 6'd0;
			por_type_q <= 1'b1;
			cause_q    <= `SYSRCC_CAUSE_RESET;
		end else begin
			if (ref_fall) begin
				sim_cnt_q <= sim_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
				ph_cnt_q  <= ph_cnt_q + 6'd1;
			end
			if (ref_fall && !pin_high && pin_cnt_q == pin_thr) begin
				cause_q <= 8'h00;
				cause_q[`SYSRCC_CAUSE_PIN] <= 1'b1;
			end
			if (lvi_rise && state_q != S_POR) begin
				state_q    <= S_POR;
				sim_cnt_q  <= {CNT_W{1'b0}};
				por_type_q <= 1'b1;
				cause_q    <= 8'h00;
				cause_q[`SYSRCC_CAUSE_LVI] <= 1'b1;
			end else if (int_req && int_ok) begin
				state_q    <= S_INT_PIN;
				sim_cnt_q  <= {CNT_W{1'b0}};
				ph_cnt_q   <= 6'd0;
				por_type_q <= 1'b0;
				cause_q    <= int_cause;
			end else if (!pin_high && pin_watch) begin
				state_q <= S_EXT;
			end else begin
				case (state_q)
				S_POR: begin
					if (ref_fall && sim_cnt_q == POR_LAST) begin
						state_q  <= S_POR_TAIL;
						ph_cnt_q <= 6'd0;
					end
				end
				S_POR_TAIL: begin
					if (ref_fall && ph_cnt_q == TAIL_LAST) begin
						state_q    <= S_RUN;
						por_type_q <= 1'b0;
					end
				end
				S_INT_PIN: begin
					if (ref_fall && ph_cnt_q == DRV_LAST) begin
						state_q  <= S_INT_HOLD;
						ph_cnt_q <= 6'd0;
					end
				end
				S_INT_HOLD: begin
					if (ref_fall && ph_cnt_q == HOLD_LAST) begin
						state_q <= S_RUN;
					end
				end
				S_EXT: begin
					if (pin_high) begin
						state_q  <= S_INT_HOLD;
						ph_cnt_q <= 6'd0;
					end
				end
				S_STOP: begin
					if (!stop_mode) begin
						state_q   <= S_STOP_REC;
						// Recovery delay is timed from the exit
						sim_cnt_q <= {CNT_W{1'b0}};
					end
				end
				S_STOP_REC: begin
					if (ref_fall && sim_cnt_q == stop_thr) begin
						state_q <= S_RUN;
					end
				end
				default: begin
					if (stop_mode) begin
						state_q   <= S_STOP;
						sim_cnt_q <= {CNT_W{1'b0}};
					end
				end
				endcase
			end
		end
	end

	// Counts reference cycles during which the pin reads low
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_cnt_q <= {CNT_W{1'b0}};
		end else if (pin_high) begin
			pin_cnt_q <= {CNT_W{1'b0}};
		end else if (ref_fall && pin_cnt_q != {CNT_W{1'b1}}) begin
			pin_cnt_q <= pin_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	wire clk_on  = (state_q != S_POR) & (state_q != S_STOP) &
	               (state_q != S_STOP_REC);
	wire rst_act = (state_q != S_RUN) & (state_q != S_STOP) &
	               (state_q != S_STOP_REC);
	wire drive   = (state_q == S_POR) | (state_q == S_INT_PIN);

	// Pin drive, internal reset, vector and gated clocks
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_pin_out_q    <= 1'b0;
			rst_pin_oe_q     <= 1'b1;
			internal_reset_q <= 1'b1;
			reset_vector_q   <= `SYSRCC_VEC_USER;
			cpu_clk_q        <= 1'b0;
			periph_clk_a_q   <= 1'b0;
			periph_clk_b_q   <= 1'b0;
		end else begin
			rst_pin_out_q    <= 1'b0;
			rst_pin_oe_q     <= drive;
			internal_reset_q <= rst_act;
			reset_vector_q   <= monitor_mode ? `SYSRCC_VEC_MONITOR :
			                    `SYSRCC_VEC_USER;
			cpu_clk_q        <= clk_on & ~wait_mode & bus_clk;
			periph_clk_a_q   <= clk_on & bus_clk;
			periph_clk_b_q   <= clk_on & ~bus_clk;
		end
	end

	// APB slave, zero wait states, answer in the access phase
	wire [15:0] widx  = paddr[17:2];
	wire        setup = psel & ~penable;
	wire        wr    = psel & penable & pready_q & pwrite;
	wire hit_bs = (widx == `SYSRCC_IDX_BREAK_STATUS);
	wire hit_rc = (widx == `SYSRCC_IDX_RESET_CAUSE);
	wire hit_bc = (widx == `SYSRCC_IDX_BREAK_CTRL);
	wire hit_cc = (widx == `SYSRCC_IDX_CLOCK_CTRL);
	wire hit    = hit_bs | hit_rc | hit_bc | hit_cc;
	wire brk_set = break_req & (wait_mode | stop_mode);
	wire brk_clr = wr & hit_bs & ~pwdata[`SYSRCC_BRK_SW_BIT] &
	               (break_flag_clear_enable_q | ~break_active);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~hit;
			if (setup) begin
				prdata_q <= 32'h0000_0000;
				if (hit_bs) begin
					prdata_q[`SYSRCC_BRK_SW_BIT] <= brk_sw_q;
				end
				if (hit_rc) begin
					prdata_q[7:0] <= cause_q;
				end
				if (hit_bc) begin
					prdata_q[`SYSRCC_BREAK_FLAG_CLEAR_ENABLE_BIT] <= break_flag_clear_enable_q;
				end
				if (hit_cc) begin
					prdata_q[`SYSRCC_PLLSEL_BIT] <= pll_select_q;
				end
			end
		end
	end

	// Writable state; reset-cause writes fall through with no effect
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brk_sw_q     <= `SYSRCC_BRK_SW_RESET;
			break_flag_clear_enable_q       <= `SYSRCC_BREAK_FLAG_CLEAR_ENABLE_RESET;
			pll_select_q <= `SYSRCC_PLLSEL_RESET;
		end else if (internal_reset_q) begin
			brk_sw_q     <= `SYSRCC_BRK_SW_RESET;
			break_flag_clear_enable_q       <= `SYSRCC_BREAK_FLAG_CLEAR_ENABLE_RESET;
			pll_select_q <= `SYSRCC_PLLSEL_RESET;
		end else begin
			if (brk_set) begin
				brk_sw_q <= 1'b1;
			end else if (brk_clr) begin
				brk_sw_q <= 1'b0;
			end
			if (wr && hit_bc) begin
				break_flag_clear_enable_q <= pwdata[`SYSRCC_BREAK_FLAG_CLEAR_ENABLE_BIT];
			end
			if (wr && hit_cc) begin
				pll_select_q <= pwdata[`SYSRCC_PLLSEL_BIT];
			end
		end
	end
endmodule

// ===== design/sysrcc_regs.vh
// Register map, field positions, reset values and counts of the reset/clock block
`ifndef SYSRCC_REGS_VH
`define SYSRCC_REGS_VH

// Register indices; byte address is four times the index
`define SYSRCC_IDX_BREAK_STATUS  16'hFE00
`define SYSRCC_IDX_RESET_CAUSE   16'hFE01
`define SYSRCC_IDX_BREAK_CTRL    16'hFE03
`define SYSRCC_IDX_CLOCK_CTRL    16'hFE08

// Reset-cause fields
`define SYSRCC_CAUSE_POR         7
`define SYSRCC_CAUSE_PIN         6
`define SYSRCC_CAUSE_WDOG        5
`define SYSRCC_CAUSE_OPCODE      4
`define SYSRCC_CAUSE_ADDR        3
`define SYSRCC_CAUSE_LVI         1
`define SYSRCC_CAUSE_RESET       8'h80

// Break status / control / clock control fields
`define SYSRCC_BRK_SW_BIT        1
`define SYSRCC_BRK_SW_RESET      1'b0
`define SYSRCC_BREAK_FLAG_CLEAR_ENABLE_BIT          7
`define SYSRCC_BREAK_FLAG_CLEAR_ENABLE_RESET        1'b0
`define SYSRCC_PLLSEL_BIT        0
`define SYSRCC_PLLSEL_RESET      1'b0

// Reset vectors
`define SYSRCC_VEC_USER          16'hFFFE
`define SYSRCC_VEC_MONITOR       16'hFEFE

// Counts in reference clock cycles
`define SYSRCC_POR_CYCLES        13'd4096
`define SYSRCC_POR_TAIL_CYCLES   7'd64
`define SYSRCC_INT_PIN_CYCLES    6'd32
`define SYSRCC_INT_HOLD_CYCLES   6'd32
`define SYSRCC_STOP_LONG_CYCLES  13'd4096
`define SYSRCC_STOP_SHORT_CYCLES 13'd32
`define SYSRCC_PIN_MIN_CYCLES    13'd67
`define SYSRCC_PIN_POR_CYCLES    13'd4163

// Bus clock is the clock generator output divided by two
`define SYSRCC_BUS_DIV           2

`endif

// ===== design/sysrcc_sync.v
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module sysrcc_sync #(
	parameter         W    = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire [W-1:0] din,
	output wire [W-1:0] level,
	output wire [W-1:0] rise,
	output wire [W-1:0] fall
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg lvl_q;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_q  <= INIT[i];
					s2_q  <= INIT[i];
					s3_q  <= INIT[i];
					lvl_q <= INIT[i];
				end else begin
					s1_q <= din[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						lvl_q <= s2_q;
					end
				end
			end
			assign level[i] = lvl_q;
			assign rise[i]  = ~lvl_q & s2_q & s3_q;
			assign fall[i]  = lvl_q & ~s2_q & ~s3_q;
		end
	endgenerate
endmodule

// ===== design/sysrcc_clkdiv.v
// Divides a stream of edge ticks into a square bus clock level
`timescale 1ns/1ps
module sysrcc_clkdiv #(
	parameter DIV = 2,
	parameter CW  = 4
) (
	input  wire pclk,
	input  wire presetn,
	input  wire tick,
	output reg  div_clk_q
);
	localparam integer  HALF_I = DIV / 2 - 1;
	localparam [CW-1:0] HALF   = HALF_I[CW-1:0];
	reg [CW-1:0] cnt_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q     <= {CW{1'b0}};
			div_clk_q <= 1'b0;
		end else if (tick) begin
			if (cnt_q == HALF) begin
				cnt_q     <= {CW{1'b0}};
				div_clk_q <= ~div_clk_q;
			end else begin
				cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule

// ===== bench/sysrcc_checker.sv
// Port assertions for the reset and clock block
`timescale 1ns/1ps
module sysrcc_checker (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        wait_mode,
	input wire [31:0] prdata_q,
	input wire        pready_q,
	input wire        pslverr_q,
	input wire        rst_pin_out_q,
	input wire        rst_pin_oe_q,
	input wire        internal_reset_q,
	input wire [15:0] reset_vector_q,
	input wire        cpu_clk_q
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence apb_setup;
		psel && !penable;
	endsequence
	sequence pin_let_go;
		$fell(rst_pin_oe_q) && internal_reset_q;
	endsequence
	AST_READY: assert property (apb_setup |=> pready_q)
		else $error("no ready after setup");
	AST_ERR_ZERO: assert property (pslverr_q |-> pready_q && prdata_q == 0)
		else $error("error answer not clean");
	AST_OPEN_DRAIN: assert property (rst_pin_out_q == 1'b0)
		else $error("reset pin driven high");
	AST_OE_IN_RESET: assert property (rst_pin_oe_q |-> internal_reset_q)
		else $error("pin pulled outside reset");
	AST_OE_MIN: assert property ($rose(rst_pin_oe_q) |=> rst_pin_oe_q [*8])
		else $error("pin pull too short");
	AST_HOLD_TAIL: assert property (pin_let_go |=> internal_reset_q [*8])
		else $error("reset tail too short");
	AST_VECTOR: assert property (reset_vector_q == 16'hFFFE ||
		reset_vector_q == 16'hFEFE)
		else $error("bad reset vector");
	AST_WAIT: assert property ((!internal_reset_q && wait_mode) [*3] |-> !cpu_clk_q)
		else $error("cpu clock runs in wait");
endmodule
bind sysrcc_top sysrcc_checker i_sysrcc_checker (.pclk, .presetn, .psel,
	.penable, .wait_mode, .prdata_q, .pready_q, .pslverr_q, .rst_pin_out_q,
	.rst_pin_oe_q, .internal_reset_q, .reset_vector_q, .cpu_clk_q);

// ===== bench/sysrcc_partner.sv
// Reference clock, clock generator output and pulled-up reset pin
`timescale 1ns/1ps
module sysrcc_partner (
	input  wire pclk,
	input  wire pull_low,
	input  wire rst_pin_out_q,
	input  wire rst_pin_oe_q,
	output reg  osc_ref_clock,
	output reg  clock_gen_output,
	output wire rst_pin_in
);
	reg [2:0] div_q = 3'd0;
	initial osc_ref_clock = 1'b0;
	initial clock_gen_output = 1'b0;
	// Reference period is eight pclk cycles, generator output four
	always @(posedge pclk) begin
		div_q <= div_q + 3'd1;
		osc_ref_clock <= div_q[2];
		clock_gen_output <= div_q[1];
	end
	// Pull-up unless the device or the outside party pulls low
	assign rst_pin_in = ((rst_pin_oe_q && !rst_pin_out_q) || pull_low) ?
		1'b0 : 1'b1;
endmodule

// ===== bench/sysrcc_top_bench.sv
// Self-checking bench for the reset and clock block
`timescale 1ns/1ps
`include "sysrcc_regs.vh"
module sysrcc_top_bench;
	localparam [17:0] A_BS = {`SYSRCC_IDX_BREAK_STATUS, 2'b00};
	localparam [17:0] A_RC = {`SYSRCC_IDX_RESET_CAUSE, 2'b00};
	localparam [17:0] A_BC = {`SYSRCC_IDX_BREAK_CTRL, 2'b00};
	localparam [17:0] A_CC = {`SYSRCC_IDX_CLOCK_CTRL, 2'b00};
	reg         pclk, presetn, psel, penable, pwrite, pull_low;
	reg  [17:0] paddr;
	reg  [31:0] pwdata, v;
	reg         low_voltage_req, watchdog_req, bad_opcode_req;
	reg         bad_address_req, monitor_mode, wait_mode, stop_mode;
	reg         short_stop_recovery, break_req, break_active, bad;
	wire [31:0] prdata_q;
	wire [15:0] reset_vector_q;
	wire        pready_q, pslverr_q, osc_ref_clock, clock_gen_output;
	wire        rst_pin_in, rst_pin_out_q, rst_pin_oe_q, pll_select_q;
	wire        internal_reset_q, cpu_clk_q, periph_clk_a_q, periph_clk_b_q;
	integer     errors, checked, cyc, seed, n, a, b, k;
	reg  [32:0] exp_q[$];
	sysrcc_top i_sysrcc_top (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q, .osc_ref_clock,
		.clock_gen_output, .rst_pin_in, .rst_pin_out_q, .rst_pin_oe_q,
		.low_voltage_req, .watchdog_req, .bad_opcode_req, .bad_address_req,
		.monitor_mode, .wait_mode, .stop_mode, .short_stop_recovery,
		.break_req, .break_active, .pll_select_q, .internal_reset_q,
		.reset_vector_q, .cpu_clk_q, .periph_clk_a_q, .periph_clk_b_q);
	sysrcc_partner i_sysrcc_partner (.pclk, .pull_low, .rst_pin_out_q,
		.rst_pin_oe_q, .osc_ref_clock, .clock_gen_output, .rst_pin_in);
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", checked, errors);
			if (errors == 0 && checked > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task cmp(input [32:0] got, input [32:0] want);
		begin
			checked = checked + 1;
			if (got !== want) begin
				errors = errors + 1;
				$display("[FAIL] %0t got %h want %h", $time, got, want);
			end
		end
	endtask
	function near(input integer x, input integer t);
		near = (x > t - 24) && (x < t + 24);
	endfunction
	task apb(input w, input [17:0] ad, input [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= ad;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			n = 0;
			while (pready_q !== 1'b1 && n < 50) begin
				@(posedge pclk);
				n = n + 1;
			end
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task rd(input [17:0] ad, input [32:0] want);
		begin
			exp_q.push_back(want);
			apb(1'b0, ad, 32'h0000_0000);
		end
	endtask
	// Counts pin-pull cycles, then the internal-reset tail
	task seq_len;
		begin
			a = 0;
			b = 0;
			bad = 1'b0;
			while (rst_pin_oe_q !== 1'b0 && a < 40000) begin
				@(posedge pclk);
				a = a + 1;
				bad = bad | (cpu_clk_q !== 1'b0);
			end
			while (internal_reset_q !== 1'b0 && b < 2000) begin
				@(posedge pclk);
				b = b + 1;
			end
		end
	endtask
	always @(posedge pclk)
		if (psel && penable && pready_q === 1'b1 && !pwrite)
			cmp({pslverr_q, prdata_q}, exp_q.pop_front());
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			errors = errors + 1;
			wrap_up;
		end
	end
	initial begin
		{psel, penable, pwrite, pull_low, low_voltage_req, watchdog_req} = 0;
		{bad_opcode_req, bad_address_req, monitor_mode, wait_mode} = 0;
		{stop_mode, short_stop_recovery, break_req, break_active} = 0;
		{paddr, pwdata, errors, checked, cyc} = 0;
		seed = 32'ha89a_6d77;
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		seq_len;
		cmp(near(a, 4096 * 8), 1);
		cmp(bad, 0);
		cmp(near(b, 64 * 8), 1);
		$display("power-on done");
		@(posedge periph_clk_a_q);
		@(posedge pclk);
		// High half of the bus clock: one generator period of four cycles
		for (n = 0; periph_clk_a_q === 1'b1 && n < 40; n = n + 1)
			@(posedge pclk);
		cmp(n, 4);
		cmp(periph_clk_b_q ^ periph_clk_a_q, 1);
		rd(A_RC, 33'h0_0000_0080);
		rd(A_BS, 33'h0_0000_0000);
		rd(A_BC, 33'h0_0000_0000);
		rd(A_BS + 18'h0_0008, 33'h1_0000_0000);
		apb(1'b1, A_RC, 32'h0000_00FF);
		rd(A_RC, 33'h0_0000_0080);
		apb(1'b1, A_BC, 32'h0000_0080);
		rd(A_BC, 33'h0_0000_0080);
		for (k = 0; k < 4; k = k + 1) begin
			v = $random(seed);
			apb(1'b1, A_CC, v);
			cmp(pll_select_q, v[0]);
		end
		$display("registers done");
		wait_mode <= 1'b1;
		break_req <= 1'b1;
		@(posedge pclk);
		break_req <= 1'b0;
		rd(A_BS, 33'h0_0000_0002);
		apb(1'b1, A_BS, 32'h0000_0000);
		rd(A_BS, 33'h0_0000_0000);
		wait_mode <= 1'b0;
		$display("break done");
		for (k = 0; k < 3; k = k + 1) begin
			monitor_mode <= (k == 0);
			{watchdog_req, bad_opcode_req, bad_address_req} <= 3'b100 >> k;
			@(posedge pclk);
			{watchdog_req, bad_opcode_req, bad_address_req} <= 3'b000;
			for (n = 0; rst_pin_oe_q !== 1'b1 && n < 20; n = n + 1)
				@(posedge pclk);
			cmp(reset_vector_q, (k == 0) ? 16'hFEFE : 16'hFFFE);
			seq_len;
			cmp(near(a, 32 * 8), 1);
			cmp(near(b, 32 * 8), 1);
			rd(A_RC, 33'h0_0000_0020 >> k);
			rd(A_BC, 33'h0_0000_0000);
		end
		monitor_mode <= 1'b0;
		$display("internal resets done");
		pull_low <= 1'b1;
		repeat (80 * 8) @(posedge pclk);
		cmp(internal_reset_q, 1);
		pull_low <= 1'b0;
		seq_len;
		cmp(near(b, 32 * 8), 1);
		rd(A_RC, 33'h0_0000_0040);
		$display("pin reset done");
		stop_mode <= 1'b1;
		short_stop_recovery <= 1'b1;
		repeat (20) @(posedge pclk);
		stop_mode <= 1'b0;
		for (n = 0; cpu_clk_q !== 1'b1 && n < 2000; n = n + 1)
			@(posedge pclk);
		cmp(near(n, 32 * 8), 1);
		$display("stop recovery done");
		wrap_up;
	end
endmodule
